// >>> hdl/serial_io_bit_led_irq.sv
// serial gpio output value generation, input interrupts and loss-of-signal forwarding
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Functional notes
// RL1: each bit picks static, blink or activity
// RL2: pwm and polarity modify every bit
// RL3: static drives fixed zero or one
// RL4: two independent blink generators, selectable
// RL5: generator zero rates 20/10/5/2.5 Hz
// RL6: generator one code three toggles per burst
// RL7: software reset of shared blink counter
// RL8: ports 0..10 follow port module activity
// RL9: envelope gates blink, off when deasserted
// RL10: activity stretches envelope by 100 ms
// RL11: source select also encodes activity polarity
// RL12: level interrupts from sampled inputs
// RL13: enabled needs port and position enable
// RL14: raw status is polarity-corrected input
// RL15: per-bit trigger level, any, fall, rise
// RL16: sticky status cleared by writing one
// RL17: identity is sticky masked by enables
// RL18: interrupt high while any identity active
// RL19: bit 0 forwarded as loss-of-signal
// RL20: port module local enable gates loss-of-signal
// RL21: overlaid gpio source ignores forwarded value
// RL22: loss-of-signal shares interrupt polarity
// RL23: 32 ports of four bits, in and out
// RL24: pwm combined by and before polarity
// RL25: trigger code 0 level .. 3 rising
module serial_io_bit_led_irq import serial_io_bit_pkg::*; #(
  parameter int TICK_CYCLES = BLINK_TICK_CYCLES,
  parameter int STRETCH_LEN = STRETCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire bus_req_type bus_req,
  output logic [31:0] rdata,
  input wire logic [NUM_BITS-1:0] serial_in,
  input wire logic burst_done,
  input wire logic [2:0] pwm_wave,
  input wire logic [ACT_PORTS-1:0] port_activity,
  input wire logic [ACT_PORTS-1:0] los_local_en,
  input wire logic [ACT_PORTS-1:0] los_gpio_sel,
  input wire logic [ACT_PORTS-1:0] los_gpio_pin,
  output logic [NUM_BITS-1:0] serial_out,
  output logic irq,
  output logic [ACT_PORTS-1:0] los_out
);
  // ==========================================================
  // register bus
  logic [31:0] gen_cfg_reg;
  logic [31:0] per_port_irq_enable;
  logic [NUM_BITS-1:0] input_polarity_sel;
  logic [NUM_BITS-1:0] trigger_mode_low;
  logic [NUM_BITS-1:0] trigger_mode_high;
  logic [NUM_BITS-1:0] irq_raw_status;
  logic [NUM_BITS-1:0] irq_sticky_status;
  logic [NUM_BITS-1:0] irq_identity_vector;
  logic [NUM_BITS-1:0] prev_raw_reg;
  logic [NUM_BITS-1:0] trig_hit;
  logic [NUM_BITS-1:0] irq_en_mask;
  bit_cfg_type bit_cfg [NUM_BITS];
  logic [1:0] blink_gen0_rate;
  logic [1:0] blink_gen1_rate;
  logic blink_counter_reset;
  logic [3:0] per_position_irq_enable;
  logic [1:0] grp;
  logic [4:0] port_idx;
  logic sticky_wr;
  logic [31:0] rdata_next;

  assign blink_gen0_rate = gen_cfg_reg[BLINK0_LSB +: 2];
  assign blink_gen1_rate = gen_cfg_reg[BLINK1_LSB +: 2];
  assign blink_counter_reset = gen_cfg_reg[BLINK_RST_BIT];
  assign per_position_irq_enable = gen_cfg_reg[POS_EN_LSB +: 4];
  assign grp = bus_req.addr[3:2];
  assign port_idx = bus_req.addr[6:2];
  assign sticky_wr = bus_req.wr && (bus_req.addr[9:4] == STICKY_BASE[9:4]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gen_cfg_reg <= 32'h0000_0000;
      per_port_irq_enable <= 32'h0000_0000;
      input_polarity_sel <= '0;
      trigger_mode_low <= '0;
      trigger_mode_high <= '0;
    end else if (ce && bus_req.wr) begin
      if (bus_req.addr == GEN_CFG_ADDR) begin
        gen_cfg_reg <= bus_req.wdata & 32'h0000_0F1F;
      end
      if (bus_req.addr == PORT_IRQ_EN_ADDR) begin
        per_port_irq_enable <= bus_req.wdata;
      end
      if (bus_req.addr[9:4] == INPUT_POL_BASE[9:4]) begin
        input_polarity_sel[32*grp +: 32] <= bus_req.wdata;
      end
      if (bus_req.addr[9:4] == TRIG_LOW_BASE[9:4]) begin
        trigger_mode_low[32*grp +: 32] <= bus_req.wdata;
      end
      if (bus_req.addr[9:4] == TRIG_HIGH_BASE[9:4]) begin
        trigger_mode_high[32*grp +: 32] <= bus_req.wdata;
      end
    end
  end

  // per-bit output configuration, one word per port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_BITS; i++) begin
        bit_cfg[i] <= '{pol: 1'b0, pwm: 2'h0, src: SRC_STATIC0};
      end
    end else if (ce && bus_req.wr && bus_req.addr[9:8] == PORT_CFG_BASE[9:8]
                 && bus_req.addr[7] == 1'b0) begin
      for (int b = 0; b < BITS_PER_PORT; b++) begin
        bit_cfg[4*port_idx + b] <= bit_cfg_type'(bus_req.wdata[BIT_CFG_W*b +: 6]);
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus_req.addr == GEN_CFG_ADDR) begin
      rdata_next = gen_cfg_reg;
    end else if (bus_req.addr == PORT_IRQ_EN_ADDR) begin
      rdata_next = per_port_irq_enable;
    end else if (bus_req.addr[9:4] == INPUT_POL_BASE[9:4]) begin
      rdata_next = input_polarity_sel[32*grp +: 32];
    end else if (bus_req.addr[9:4] == TRIG_LOW_BASE[9:4]) begin
      rdata_next = trigger_mode_low[32*grp +: 32];
    end else if (bus_req.addr[9:4] == TRIG_HIGH_BASE[9:4]) begin
      rdata_next = trigger_mode_high[32*grp +: 32];
    end else if (bus_req.addr[9:4] == RAW_BASE[9:4]) begin
      rdata_next = irq_raw_status[32*grp +: 32];
    end else if (bus_req.addr[9:4] == STICKY_BASE[9:4]) begin
      rdata_next = irq_sticky_status[32*grp +: 32];
    end else if (bus_req.addr[9:4] == IDENT_BASE[9:4]) begin
      rdata_next = irq_identity_vector[32*grp +: 32];
    end else if (bus_req.addr[9:8] == PORT_CFG_BASE[9:8] && bus_req.addr[7] == 1'b0) begin
      for (int b = 0; b < BITS_PER_PORT; b++) begin
        rdata_next[BIT_CFG_W*b +: 6] = bit_cfg[4*port_idx + b];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (ce && bus_req.rd) begin
      rdata <= rdata_next;
    end
  end

  // ==========================================================
  // blink generators
  logic [CNT_W-1:0] tick_cnt_reg;
  // four divider bits so rate code three reaches the slowest blink
  logic [3:0] blink_div_reg;
  logic burst_tog_reg;
  logic [1:0] blink_wave;

  always_ff @(posedge core_clk) begin
    if (rst || (ce && blink_counter_reset)) begin
      tick_cnt_reg <= '0; // RL7
      blink_div_reg <= 4'h0;
    end else if (ce) begin
      if (tick_cnt_reg == CNT_W'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= '0;
        blink_div_reg <= blink_div_reg + 4'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      burst_tog_reg <= 1'b0;
    end else if (ce && burst_done) begin
      burst_tog_reg <= ~burst_tog_reg; // RL6
    end
  end

  // rate code r selects div bit r: 20, 10, 5, 2.5 Hz; generator one code three takes the burst toggle
  assign blink_wave[0] = blink_div_reg[blink_gen0_rate]; // RL5 RL4
  assign blink_wave[1] = (blink_gen1_rate == RATE_BURST) ? burst_tog_reg :
                         blink_div_reg[blink_gen1_rate]; // RL6 RL4

  // ==========================================================
  // activity envelope
  logic [CNT_W-1:0] env_cnt_reg [ACT_PORTS];
  logic [NUM_PORTS-1:0] envelope;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int p = 0; p < ACT_PORTS; p++) begin
        env_cnt_reg[p] <= '0;
      end
    end else if (ce) begin
      for (int p = 0; p < ACT_PORTS; p++) begin
        if (port_activity[p]) begin
          env_cnt_reg[p] <= CNT_W'(STRETCH_LEN); // RL10
        end else if (env_cnt_reg[p] != '0) begin
          env_cnt_reg[p] <= env_cnt_reg[p] - CNT_W'(1);
        end
      end
    end
  end

  always_comb begin
    envelope = '0;
    for (int p = 0; p < ACT_PORTS; p++) begin
      envelope[p] = env_cnt_reg[p] != '0; // RL8
    end
  end

  // ==========================================================
  // output values
  logic [NUM_BITS-1:0] out_next;

  always_comb begin
    for (int i = 0; i < NUM_BITS; i++) begin
      logic m;
      logic env;
      m = 1'b0;
      env = envelope[i/4];
      unique case (bit_cfg[i].src) // RL1
        SRC_STATIC0: m = 1'b0; // RL3
        SRC_STATIC1: m = 1'b1; // RL3
        SRC_BLINK0: m = blink_wave[0];
        SRC_BLINK1: m = blink_wave[1];
        SRC_ACT_B0: m = env & blink_wave[0]; // RL9
        SRC_ACT_B1: m = env & blink_wave[1]; // RL9
        SRC_ACT_INV_B0: m = ~(env & blink_wave[0]); // RL11
        SRC_ACT_INV_B1: m = ~(env & blink_wave[1]); // RL11
      endcase
      if (bit_cfg[i].pwm != 2'h0) begin
        m = m & pwm_wave[bit_cfg[i].pwm - 2'h1]; // RL24 RL2
      end
      out_next[i] = m ^ bit_cfg[i].pol; // RL2
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_out <= '0;
    end else if (ce) begin
      serial_out <= out_next; // RL23
    end
  end

  // ==========================================================
  // interrupts
  assign irq_raw_status = serial_in ^ input_polarity_sel; // RL14 RL12

  always_comb begin
    for (int i = 0; i < NUM_BITS; i++) begin
      unique case (trig_type'({trigger_mode_high[i], trigger_mode_low[i]})) // RL25 RL15
        TRIG_LEVEL: trig_hit[i] = irq_raw_status[i];
        TRIG_ANY: trig_hit[i] = irq_raw_status[i] ^ prev_raw_reg[i];
        TRIG_FALL: trig_hit[i] = prev_raw_reg[i] & ~irq_raw_status[i];
        TRIG_RISE: trig_hit[i] = ~prev_raw_reg[i] & irq_raw_status[i];
      endcase
      irq_en_mask[i] = per_port_irq_enable[i/4] & per_position_irq_enable[i%4]; // RL13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_raw_reg <= '0;
      irq_sticky_status <= '0;
    end else if (ce) begin
      prev_raw_reg <= irq_raw_status;
      // a new hit wins over a clear in the same cycle
      irq_sticky_status <= (irq_sticky_status &
        ~(sticky_wr ? (NUM_BITS'(bus_req.wdata) << (32*grp)) : '0)) | trig_hit; // RL16
    end
  end

  assign irq_identity_vector = irq_sticky_status & irq_en_mask; // RL17

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |irq_identity_vector; // RL18 RL12
    end
  end

  // ==========================================================
  // loss of signal
  logic [ACT_PORTS-1:0] pin_s1, pin_s2, pin_s3, pin_filt;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_filt <= '0;
    end else if (ce) begin
      pin_s1 <= los_gpio_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int p = 0; p < ACT_PORTS; p++) begin
        if (pin_s2[p] == pin_s3[p]) begin
          pin_filt[p] <= pin_s3[p];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      los_out <= '0;
    end else if (ce) begin
      for (int p = 0; p < ACT_PORTS; p++) begin
        los_out[p] <= los_local_en[p] & // RL20
          (los_gpio_sel[p] ? pin_filt[p] : irq_raw_status[4*p]); // RL21 RL19 RL22
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  static_out_a: assert property ( // RL3
    ce && bit_cfg[8].src == SRC_STATIC1 && bit_cfg[8].pwm == 2'h0 && !bit_cfg[8].pol
    |=> serial_out[8]) else $error("static one not driven");
  pwm_gate_a: assert property ( // RL24
    ce && bit_cfg[10].pwm == 2'h1 && !pwm_wave[0] && !bit_cfg[10].pol
    |=> !serial_out[10]) else $error("pwm did not gate output");
  inv_act_a: assert property ( // RL11
    ce && bit_cfg[5].src == SRC_ACT_INV_B1 && bit_cfg[5].pwm == 2'h0 && !bit_cfg[5].pol
    && !envelope[1] |=> serial_out[5]) else $error("inverted activity not idle high");
  burst_toggle_a: assert property ( // RL6
    ce && burst_done |=> burst_tog_reg != $past(burst_tog_reg))
    else $error("burst toggle missed");
  sticky_hold_a: assert property ( // RL16
    irq_sticky_status[5] && !(sticky_wr && grp == 2'h0 && bus_req.wdata[5])
    |=> irq_sticky_status[5]) else $error("sticky bit lost");
  sticky_clear_a: assert property ( // RL16
    ce && sticky_wr && grp == 2'h0 && bus_req.wdata[5] && !trig_hit[5]
    |=> !irq_sticky_status[5]) else $error("sticky bit not cleared");
  rise_trig_a: assert property ( // RL15
    ce && trigger_mode_high[5] && trigger_mode_low[5] && $rose(irq_raw_status[5])
    |=> irq_sticky_status[5]) else $error("rising edge missed");
  irq_level_a: assert property ( // RL18
    ce && (|irq_identity_vector) |=> irq) else $error("irq not raised");
  irq_drop_a: assert property ( // RL18
    ce && !(|irq_identity_vector) |=> !irq) else $error("irq not dropped");
  port_mask_a: assert property ( // RL13
    !per_port_irq_enable[1] |-> irq_identity_vector[7:4] == 4'h0)
    else $error("disabled port in identity");
  los_fwd_a: assert property ( // RL19
    ce && los_local_en[1] && !los_gpio_sel[1]
    |=> los_out[1] == $past(irq_raw_status[4]))
    else $error("loss of signal not forwarded");
  los_off_a: assert property ( // RL20
    ce && !los_local_en[1] |=> !los_out[1]) else $error("loss of signal not gated");
  stretch_load_a: assert property ( // RL10
    ce && port_activity[1] |=> env_cnt_reg[1] == CNT_W'(STRETCH_LEN))
    else $error("envelope not reloaded");
  env_decay_a: assert property ( // RL10
    ce && !port_activity[1] && env_cnt_reg[1] != '0
    |=> env_cnt_reg[1] == $past(env_cnt_reg[1]) - CNT_W'(1))
    else $error("envelope not counting down");
  blink_reset_a: assert property ( // RL7
    ce && blink_counter_reset |=> tick_cnt_reg == '0 && blink_div_reg == 4'h0)
    else $error("blink counter not reset");

  irq_rise_c: cover property (ce && $rose(irq));
  env_expire_c: cover property (ce && $fell(envelope[1]));
  burst_tog_c: cover property (ce && burst_done && blink_gen1_rate == RATE_BURST);
  los_gpio_c: cover property (ce && los_gpio_sel[1] && los_local_en[1] && pin_filt[1]);
endmodule

// >>> hdl/serial_io_bit_pkg.sv
// shared constants and types for the serial gpio output and interrupt block
package serial_io_bit_pkg;
  localparam int NUM_PORTS = 32;
  localparam int BITS_PER_PORT = 4;
  localparam int NUM_BITS = 128;
  localparam int ACT_PORTS = 11;
  localparam int CLK_MHZ = 100;
  localparam int BLINK_TICK_US = 25000;
  localparam int BLINK_TICK_CYCLES = BLINK_TICK_US * CLK_MHZ;
  localparam int STRETCH_MS = 100;
  localparam int STRETCH_CYCLES = STRETCH_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 10;
  // register byte addresses
  localparam logic [9:0] GEN_CFG_ADDR = 10'h000;
  localparam logic [9:0] PORT_IRQ_EN_ADDR = 10'h004;
  localparam logic [9:0] INPUT_POL_BASE = 10'h010;
  localparam logic [9:0] TRIG_LOW_BASE = 10'h020;
  localparam logic [9:0] TRIG_HIGH_BASE = 10'h030;
  localparam logic [9:0] RAW_BASE = 10'h040;
  localparam logic [9:0] STICKY_BASE = 10'h050;
  localparam logic [9:0] IDENT_BASE = 10'h060;
  localparam logic [9:0] PORT_CFG_BASE = 10'h100;
  // general config field positions, per-bit config stride and burst rate code
  localparam int BLINK0_LSB = 0;
  localparam int BLINK1_LSB = 2;
  localparam int BLINK_RST_BIT = 4;
  localparam int POS_EN_LSB = 8;
  localparam int BIT_CFG_W = 8;
  localparam logic [1:0] RATE_BURST = 2'h3;
  typedef enum logic [2:0] {
    SRC_STATIC0, SRC_STATIC1, SRC_BLINK0, SRC_BLINK1,
    SRC_ACT_B0, SRC_ACT_B1, SRC_ACT_INV_B0, SRC_ACT_INV_B1
  } out_src_type;
  typedef enum logic [1:0] {TRIG_LEVEL, TRIG_ANY, TRIG_FALL, TRIG_RISE} trig_type;
  typedef struct packed {
    logic pol;
    logic [1:0] pwm;
    out_src_type src;
  } bit_cfg_type;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
endpackage

// >>> verif/sio_chain_model.sv
// behavioural model of the external serial-parallel shift register chain
`timescale 1ns/100ps
module sio_chain_model import serial_io_bit_pkg::*; (
  input wire logic core_clk,
  input wire logic burst_done,
  input wire logic [NUM_BITS-1:0] serial_out,
  input wire logic [NUM_BITS-1:0] pin_vals,
  output logic [NUM_BITS-1:0] serial_in,
  output logic [NUM_BITS-1:0] led_vals
);
  // inputs and outputs move only when a burst completes
  initial serial_in = '0;
  initial led_vals = '0;
  always @(posedge core_clk) begin
    if (burst_done) begin
      serial_in <= pin_vals;
      led_vals <= serial_out;
    end
  end
endmodule

// >>> verif/serial_gpio_led_interrupt_logic_tb.sv
// self-checking bench for the serial gpio led and interrupt block
`timescale 1ns/100ps
module serial_gpio_led_interrupt_logic_tb import serial_io_bit_pkg::*;;
  localparam int TICK = 4;
  localparam int STR = 20;
  logic core_clk, rst, ce, burst_done, irq;
  bus_req_type bus_req;
  logic [31:0] rdata;
  logic [NUM_BITS-1:0] serial_in, serial_out, pins;
  logic [2:0] pwm_wave;
  logic [ACT_PORTS-1:0] act, los_en, los_sel, los_pin, los_out;
  int n_errors = 0;
  int comparisons = 0;
  serial_io_bit_led_irq #(.TICK_CYCLES(TICK), .STRETCH_LEN(STR)) dut_u (
    .core_clk(core_clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
    .serial_in(serial_in), .burst_done(burst_done), .pwm_wave(pwm_wave),
    .port_activity(act), .los_local_en(los_en), .los_gpio_sel(los_sel),
    .los_gpio_pin(los_pin), .serial_out(serial_out), .irq(irq), .los_out(los_out));
  sio_chain_model chain_u (.core_clk(core_clk), .burst_done(burst_done),
    .serial_out(serial_out), .pin_vals(pins), .serial_in(serial_in), .led_vals());
  // ====================
  // shared tasks
  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic burst();
    @(posedge core_clk);
    burst_done <= 1'b1;
    @(posedge core_clk);
    burst_done <= 1'b0;
    cyc(3);
  endtask
  task automatic pin(input int idx, input logic v);
    @(posedge core_clk);
    pins[idx] <= v;
    burst();
  endtask
  task automatic act_pulse();
    @(posedge core_clk);
    act <= 11'h002;
    @(posedge core_clk);
    act <= '0;
  endtask
  // cycles until the next change of one output bit
  task automatic gap(input int idx, output int n);
    logic v;
    v = serial_out[idx];
    n = 0;
    while (serial_out[idx] === v) begin
      cyc(1);
      n++;
      if (n > 200) begin
        n_errors++;
        final_report();
      end
    end
  endtask
  // ====================
  // scenarios
  task automatic t_static();
    wr(PORT_CFG_BASE + 10'h008, 32'h1109_2101);
    wr(PORT_CFG_BASE + 10'h00C, 32'h0000_0019);
    cyc(3);
    check(serial_out[12:8], 5'h09);
    @(posedge core_clk);
    pwm_wave <= 3'b101;
    cyc(3);
    check(serial_out[12:8], 5'h15);
  endtask
  task automatic t_act();
    wr(PORT_CFG_BASE, 32'h3);
    wr(PORT_CFG_BASE + 10'h004, 32'h0604_0705);
    wr(PORT_CFG_BASE + 10'h02C, 32'h5);
    wr(GEN_CFG_ADDR, 32'h0C);
    cyc(3);
    check({serial_out[7:4], serial_out[0]}, 5'h14);
    burst();
    check({serial_out[7:4], serial_out[0]}, 5'h15);
    act_pulse();
    cyc(3);
    check({serial_out[44], serial_out[5:4]}, 3'b001);
    check(serial_out[7] ^ serial_out[6], 1'b1);
    cyc(6);
    act_pulse();
    cyc(14);
    check(serial_out[4], 1'b1);
    cyc(20);
    check(serial_out[7:4], 4'hA);
  endtask
  task automatic t_blink();
    int n;
    wr(PORT_CFG_BASE, 32'h0200);
    for (int r = 0; r < 4; r++) begin
      wr(GEN_CFG_ADDR, r);
      repeat (3) gap(1, n);
      check(n, TICK << r);
    end
    wr(GEN_CFG_ADDR, 32'h10);
    cyc(3);
    check(serial_out[1], 1'b0);
    cyc(40);
    check(serial_out[1], 1'b0);
  endtask
  task automatic t_irq();
    pin(5, 1'b1);
    rd(RAW_BASE, 32'h20);
    wr(INPUT_POL_BASE, 32'h20);
    rd(RAW_BASE, 32'h0);
    wr(INPUT_POL_BASE, 32'h0);
    for (int m = 0; m < 4; m++) begin
      pin(5, 1'b0);
      wr(TRIG_LOW_BASE, m[0] ? 32'h20 : 32'h0);
      wr(TRIG_HIGH_BASE, m[1] ? 32'h20 : 32'h0);
      wr(STICKY_BASE, 32'h20);
      pin(5, 1'b1);
      rd(STICKY_BASE, (m != 2) ? 32'h20 : 32'h0);
      wr(STICKY_BASE, 32'h20);
      rd(STICKY_BASE, (m == 0) ? 32'h20 : 32'h0);
      pin(5, 1'b0);
      rd(STICKY_BASE, (m != 3) ? 32'h20 : 32'h0);
    end
    wr(TRIG_LOW_BASE, 32'h0);
    wr(TRIG_HIGH_BASE, 32'h0);
    pin(5, 1'b1);
    wr(PORT_IRQ_EN_ADDR, 32'h2);
    cyc(3);
    check(irq, 1'b0);
    wr(GEN_CFG_ADDR, 32'h200);
    cyc(3);
    check(irq, 1'b1);
    rd(IDENT_BASE, 32'h20);
    wr(PORT_IRQ_EN_ADDR, 32'h0);
    rd(IDENT_BASE, 32'h0);
    cyc(2);
    check(irq, 1'b0);
    wr(PORT_IRQ_EN_ADDR, 32'h2);
    pin(5, 1'b0);
    check(irq, 1'b1);
    wr(STICKY_BASE, 32'h20);
    cyc(3);
    check(irq, 1'b0);
  endtask
  task automatic t_los();
    pin(4, 1'b1);
    check(los_out[1], 1'b1);
    wr(INPUT_POL_BASE, 32'h10);
    cyc(2);
    check(los_out[1], 1'b0);
    wr(INPUT_POL_BASE, 32'h0);
    @(posedge core_clk);
    los_en[1] <= 1'b0;
    cyc(3);
    check(los_out[1], 1'b0);
    @(posedge core_clk);
    los_en[1] <= 1'b1;
    los_sel[1] <= 1'b1;
    cyc(8);
    check(los_out[1], 1'b0);
    @(posedge core_clk);
    los_pin[1] <= 1'b1;
    cyc(8);
    check(los_out[1], 1'b1);
  endtask
  // ====================
  // clock, reset and sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus_req = '0;
    burst_done = 1'b0;
    pins = '0;
    pwm_wave = 3'b010;
    act = '0;
    los_en = '1;
    los_sel = '0;
    los_pin = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    check({irq, los_out, serial_out[19:0]}, 32'h0);
    check(serial_out[51:20], 32'h0);
    rd(10'h3FC, 32'h0);
    t_static();
    t_act();
    t_blink();
    t_irq();
    t_los();
    final_report();
  end
endmodule
